// *** hdl/optical_sensor_ctrl.sv ***
// What this block does
// - Average 1..32 samples per channel, code-selected
// - Wrap enabled: full FIFO overwrites oldest samples
// - Wrap disabled: full FIFO drops samples until freed
// - Almost-full when empty entries equal threshold
// - Power-save keeps registers, serial access still works
// - Power-save forces interrupt indication low
// - Soft reset restores all registers to defaults
// - Soft-reset bit self-clears when sequence ends
// - Soft reset never raises power-ready event
// - Mode change leaves settings and data intact
// - Mode codes 010, 011, 111; others forbidden
// - Two-bit ADC range select drives converter scale
// - FIFO config: average, wrap, threshold; resets zero
// - Circular 32-sample FIFO, three bytes per channel
// - Data register burst keeps address, advances index
// - Write index on store, read index on read
`timescale 1ns/10ps
`default_nettype none
module optical_sensor_ctrl #(
   parameter logic [6:0] DEVICE_ADDR       = 7'h2a,
   parameter int         SOFT_RESET_CYCLES = 16
) (
   // Clock and reset
   input  wire logic                           clock,
   input  wire logic                           rst_b,
   // Serial register port
   input  wire logic                           scl,
   input  wire logic                           sda_in,
   output var  logic                           sda_out,
   output var  logic                           sda_oe,
   // Converter samples
   input  wire logic                           acq_valid,
   input  wire logic [sensor_pkg::SAMPLE_W-1:0] acq_red,
   input  wire logic [sensor_pkg::SAMPLE_W-1:0] acq_ir,
   output var  logic                           acquisition_enable,
   output var  logic [2:0]                     active_mode,
   output var  logic [1:0]                     adc_full_scale_select,
   output var  logic                           power_save_request,
   // Events
   input  wire logic                           almost_full_ack,
   output var  logic                           almost_full_irq,
   output var  logic                           power_ready_event,
   output var  logic                           soft_reset_busy
);
   import sensor_pkg::*;

   localparam logic [7:0] SRST_LAST = 8'(SOFT_RESET_CYCLES - 1);

   logic [1:0]          rst_pipe;
   logic [7:0]          fifo_configuration;
   logic [7:0]          mode_configuration;
   logic [7:0]          acquisition_configuration;
   logic [IDX_W-1:0]    wr_idx;
   logic [IDX_W-1:0]    rd_idx;
   logic [IDX_W-1:0]    ovf_count;
   logic                full;
   logic [IDX_W-1:0]    next_wr;
   logic [IDX_W-1:0]    next_rd;
   logic [IDX_W-1:0]    next_ovf;
   logic                next_full;
   logic [WORD_W-1:0]   mem [0:31];
   logic [WORD_W-1:0]   hold_word;
   logic [2:0]          byte_pos;
   logic [ACC_W-1:0]    acc_red;
   logic [ACC_W-1:0]    acc_ir;
   logic [5:0]          avg_cnt;
   logic                af_flag;
   logic                eval_q;
   logic                srst_busy;
   logic [7:0]          srst_cnt;
   logic                pr_pending;
   wire                 rst_sync_b = rst_pipe[1];

   reg_if bus ();

   serial_link #(
      .DEVICE_ADDR (DEVICE_ADDR)
   ) u_link (
      .clock  (clock),
      .rst_b  (rst_sync_b),
      .scl    (scl),
      .sda_in (sda_in),
      .sda_oe (sda_oe),
      .bus    (bus.link)
   );

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   function automatic logic [2:0] avg_shift(input logic [2:0] code);
      avg_shift = (code > AVG_SHIFT_MAX) ? AVG_SHIFT_MAX : code;
   endfunction

   function automatic logic [7:0] pick_byte(input logic [WORD_W-1:0] w, input logic [2:0] k);
      case (k)
         3'h0:    pick_byte = {6'h00, w[35:34]};
         3'h1:    pick_byte = w[33:26];
         3'h2:    pick_byte = w[25:18];
         3'h3:    pick_byte = {6'h00, w[17:16]};
         3'h4:    pick_byte = w[15:8];
         default: pick_byte = w[7:0];
      endcase
   endfunction

   // Register decode
   wire host_wr   = bus.wr_strobe;
   wire wr_fcfg   = host_wr & (bus.addr == REG_FIFO_CONFIG);
   wire wr_mode   = host_wr & (bus.addr == REG_MODE_CONFIG);
   wire wr_acq    = host_wr & (bus.addr == REG_ACQ_CONFIG);
   wire wr_widx   = host_wr & (bus.addr == REG_WRITE_INDEX);
   wire wr_ovf    = host_wr & (bus.addr == REG_OVERFLOW_COUNT);
   wire wr_ridx   = host_wr & (bus.addr == REG_READ_INDEX);
   wire idx_write = wr_widx | wr_ovf | wr_ridx;
   wire data_rd   = bus.rd_strobe & (bus.addr == REG_FIFO_DATA);

   wire [2:0] mode_code  = mode_configuration[MODE_MSB:MODE_LSB];
   wire       power_save = mode_configuration[SAVE_BIT];
   wire       wrap_en    = fifo_configuration[WRAP_BIT];
   wire [3:0] threshold  = fifo_configuration[THR_MSB:THR_LSB];
   wire       mode_valid = (mode_code == MODE_HEART) | (mode_code == MODE_OXY)
                         | (mode_code == MODE_MULTI);
   // reserved modes and power-save halt acquisition
   wire       acquiring  = mode_valid & ~power_save & ~srst_busy;
   wire       srst_done  = srst_busy & (srst_cnt == SRST_LAST);
   wire [2:0] bytes_per  = (mode_code == MODE_HEART) ? BYTES_SINGLE : BYTES_DUAL;

   wire [2:0]       shift_sel = avg_shift(fifo_configuration[AVG_MSB:AVG_LSB]);
   wire [5:0]       avg_last  = (6'h01 << shift_sel) - 6'h01;
   wire [ACC_W-1:0] sum_red   = acc_red + {5'h00, acq_red};
   wire [ACC_W-1:0] sum_ir    = acc_ir + {5'h00, acq_ir};
   wire             take      = acq_valid & acquiring;
   wire             store     = take & (avg_cnt == avg_last);
   wire [ACC_W-1:0] avg_red   = sum_red >> shift_sel;
   wire [ACC_W-1:0] avg_ir    = sum_ir >> shift_sel;

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         acc_red <= '0;
         acc_ir  <= '0;
         avg_cnt <= 6'h00;
      end else if (srst_done || !acquiring || store) begin
         acc_red <= '0;
         acc_ir  <= '0;
         avg_cnt <= 6'h00;
      end else if (take) begin
         acc_red <= sum_red;
         acc_ir  <= sum_ir;
         avg_cnt <= avg_cnt + 6'h01;
      end
   end

   // 32-deep circular store; full flag separates full from empty
   wire [5:0] fill     = full ? FIFO_DEPTH : {1'b0, wr_idx - rd_idx};
   wire       empty    = fill == 6'h00;
   wire       pop      = data_rd & (byte_pos == 3'h0) & ~empty;
   wire       full_eff = full & ~pop;
   wire       mem_we   = store & (~full_eff | wrap_en);

   always_comb begin
      next_wr   = wr_idx;
      next_rd   = rd_idx;
      next_ovf  = ovf_count;
      next_full = full;
      // read index follows first byte of each sample
      if (pop) begin
         next_rd   = rd_idx + 5'h01;
         next_full = 1'b0;
      end
      if (store && !full_eff) begin
         // write index follows each stored sample
         next_wr   = wr_idx + 5'h01;
         next_full = (wr_idx + 5'h01) == next_rd;
      end else if (store && wrap_en) begin
         // overwrite oldest and drag read index along
         next_wr  = wr_idx + 5'h01;
         next_rd  = rd_idx + 5'h01;
         next_ovf = (ovf_count != OVF_MAX) ? ovf_count + 5'h01 : ovf_count;
      end else if (store) begin
         // sample dropped, only the loss is counted
         next_ovf = (ovf_count != OVF_MAX) ? ovf_count + 5'h01 : ovf_count;
      end
      // host index writes win and reopen a stalled store
      if (wr_widx) begin
         next_wr   = bus.wr_data[IDX_W-1:0];
         next_full = 1'b0;
      end
      if (wr_ridx) begin
         next_rd   = bus.wr_data[IDX_W-1:0];
         next_full = 1'b0;
      end
      if (wr_ovf) begin
         next_ovf = bus.wr_data[IDX_W-1:0];
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wr_idx    <= '0;
         rd_idx    <= '0;
         ovf_count <= '0;
         full      <= 1'b0;
      end else if (srst_done) begin
         wr_idx    <= '0;
         rd_idx    <= '0;
         ovf_count <= '0;
         full      <= 1'b0;
      end else begin
         wr_idx    <= next_wr;
         rd_idx    <= next_rd;
         ovf_count <= next_ovf;
         full      <= next_full;
      end
   end

   // Sample memory has no reset; indexes decide what is valid
   always_ff @(posedge clock) begin
      if (mem_we) begin
         mem[wr_idx] <= {avg_red[SAMPLE_W-1:0], avg_ir[SAMPLE_W-1:0]};
      end
   end

   // byte position within sample, held word for later bytes
   wire [WORD_W-1:0] cur_word  = (byte_pos == 3'h0) ? mem[rd_idx] : hold_word;
   wire [7:0]        data_byte = pick_byte(cur_word, byte_pos);

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         byte_pos  <= 3'h0;
         hold_word <= '0;
      end else if (srst_done || bus.ptr_load) begin
         byte_pos <= 3'h0;
      end else if (data_rd) begin
         byte_pos  <= (byte_pos == bytes_per - 3'h1) ? 3'h0 : byte_pos + 3'h1;
         hold_word <= cur_word;
      end
   end

   // configuration registers return to defaults on soft reset
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         fifo_configuration        <= FIFO_CONFIG_RESET;
         mode_configuration        <= MODE_CONFIG_RESET;
         acquisition_configuration <= ACQ_CONFIG_RESET;
      end else if (srst_done) begin
         fifo_configuration        <= FIFO_CONFIG_RESET;
         mode_configuration        <= MODE_CONFIG_RESET;
         acquisition_configuration <= ACQ_CONFIG_RESET;
      end else begin
         if (wr_fcfg) begin
            fifo_configuration <= bus.wr_data;
         end
         // mode write touches only this register
         if (wr_mode) begin
            mode_configuration <= bus.wr_data & MODE_WRITE_MASK;
         end
         if (wr_acq) begin
            acquisition_configuration <= bus.wr_data;
         end
      end
   end

   // busy bit reads back until the sequence ends
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         srst_busy <= 1'b0;
         srst_cnt  <= 8'h00;
      end else if (srst_done) begin
         srst_busy <= 1'b0;
         srst_cnt  <= 8'h00;
      end else if (srst_busy) begin
         srst_cnt <= srst_cnt + 8'h01;
      end else if (wr_mode && bus.wr_data[SRST_BIT]) begin
         srst_busy <= 1'b1;
         srst_cnt  <= 8'h00;
      end
   end

   // only release of the hard reset announces power-ready
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         pr_pending        <= 1'b1;
         power_ready_event <= 1'b0;
      end else begin
         pr_pending        <= 1'b0;
         power_ready_event <= pr_pending;
      end
   end

   wire af_hit = fill == (FIFO_DEPTH - {2'h0, threshold});

   // re-check after store or index change; set beats acknowledge
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         eval_q  <= 1'b0;
         af_flag <= 1'b0;
      end else begin
         eval_q <= mem_we | idx_write | pop;
         if (srst_done || power_save) begin
            af_flag <= 1'b0;
         end else if (eval_q && af_hit) begin
            af_flag <= 1'b1;
         end else if (almost_full_ack) begin
            af_flag <= 1'b0;
         end
      end
   end

   assign almost_full_irq = af_flag & ~power_save;

   wire [7:0] mode_read = {mode_configuration[7], srst_busy, mode_configuration[5:0]};
   assign bus.rd_data =
        (bus.addr == REG_WRITE_INDEX)    ? {3'h0, wr_idx}
      : (bus.addr == REG_OVERFLOW_COUNT) ? {3'h0, ovf_count}
      : (bus.addr == REG_READ_INDEX)     ? {3'h0, rd_idx}
      : (bus.addr == REG_FIFO_DATA)      ? data_byte
      : (bus.addr == REG_FIFO_CONFIG)    ? fifo_configuration
      : (bus.addr == REG_MODE_CONFIG)    ? mode_read
      : (bus.addr == REG_ACQ_CONFIG)     ? acquisition_configuration
      : READ_ZERO;

   assign sda_out               = LINE_LOW;
   assign acquisition_enable    = acquiring;
   assign active_mode           = mode_code;
   // range code goes straight to the converter
   assign adc_full_scale_select = acquisition_configuration[RANGE_MSB:RANGE_LSB];
   assign power_save_request    = power_save;
   assign soft_reset_busy       = srst_busy;
endmodule
`default_nettype wire

// *** hdl/sensor_pkg.sv ***
package sensor_pkg;

   // Register map
   localparam logic [7:0] REG_WRITE_INDEX    = 8'h04;
   localparam logic [7:0] REG_OVERFLOW_COUNT = 8'h05;
   localparam logic [7:0] REG_READ_INDEX     = 8'h06;
   localparam logic [7:0] REG_FIFO_DATA      = 8'h07;
   localparam logic [7:0] REG_FIFO_CONFIG    = 8'h08;
   localparam logic [7:0] REG_MODE_CONFIG    = 8'h09;
   localparam logic [7:0] REG_ACQ_CONFIG     = 8'h0a;
   localparam logic [7:0] REG_LAST           = 8'hff;
   localparam logic [7:0] READ_ZERO          = 8'h00;

   // Reset values
   localparam logic [7:0] FIFO_CONFIG_RESET = 8'h00;
   localparam logic [7:0] MODE_CONFIG_RESET = 8'h00;
   localparam logic [7:0] ACQ_CONFIG_RESET  = 8'h00;

   // Field positions
   localparam int AVG_MSB   = 7;
   localparam int AVG_LSB   = 5;
   localparam int WRAP_BIT  = 4;
   localparam int THR_MSB   = 3;
   localparam int THR_LSB   = 0;
   localparam int SAVE_BIT  = 7;
   localparam int SRST_BIT  = 6;
   localparam int MODE_MSB  = 2;
   localparam int MODE_LSB  = 0;
   localparam int RANGE_MSB = 6;
   localparam int RANGE_LSB = 5;
   localparam logic [7:0] MODE_WRITE_MASK = 8'hbf;

   // Acquisition mode codes
   localparam logic [2:0] MODE_HEART = 3'b010;
   localparam logic [2:0] MODE_OXY   = 3'b011;
   localparam logic [2:0] MODE_MULTI = 3'b111;

   // Averaging
   localparam logic [2:0] AVG_SHIFT_MAX = 3'h5;
   localparam int         ACC_W         = 23;

   // Sample store
   localparam int         IDX_W        = 5;
   localparam int         SAMPLE_W     = 18;
   localparam int         WORD_W       = 2 * SAMPLE_W;
   localparam logic [5:0] FIFO_DEPTH   = 6'h20;
   localparam logic [4:0] OVF_MAX      = 5'h1f;
   localparam logic [2:0] BYTES_SINGLE = 3'h3;
   localparam logic [2:0] BYTES_DUAL   = 3'h6;

   // Serial link
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic       LINE_LOW      = 1'b0;

   typedef enum logic [2:0] {
      LINK_IDLE,
      LINK_ADDR,
      LINK_ADDR_ACK,
      LINK_WRITE,
      LINK_WRITE_ACK,
      LINK_READ,
      LINK_READ_ACK
   } link_state_e;

endpackage

// *** hdl/reg_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface reg_if;
   logic [7:0] addr;
   logic       wr_strobe;
   logic [7:0] wr_data;
   logic       rd_strobe;
   logic [7:0] rd_data;
   logic       ptr_load;

   modport link (
      output addr,
      output wr_strobe,
      output wr_data,
      output rd_strobe,
      output ptr_load,
      input  rd_data
   );
   modport regs (
      input  addr,
      input  wr_strobe,
      input  wr_data,
      input  rd_strobe,
      input  ptr_load,
      output rd_data
   );
endinterface
`default_nettype wire

// *** hdl/serial_link.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_link #(
   parameter logic [6:0] DEVICE_ADDR = 7'h2a
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // Serial pins
   input  wire logic scl,
   input  wire logic sda_in,
   output var  logic sda_oe,
   // Register side
   reg_if.link       bus
);
   import sensor_pkg::*;

   logic [1:0]  scl_sync;
   logic [1:0]  sda_sync;
   logic        scl_q;
   logic        sda_q;
   link_state_e state;
   logic [3:0]  bit_cnt;
   logic [7:0]  shift;
   logic [7:0]  tx;
   logic        reading;
   logic        pointer_phase;
   logic        master_nack;
   logic [7:0]  ptr;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl};
         sda_sync <= {sda_sync[0], sda_in};
         scl_q    <= scl_sync[1];
         sda_q    <= sda_sync[1];
      end
   end

   wire scl_now    = scl_sync[1];
   wire sda_now    = sda_sync[1];
   wire start_seen = scl_now & scl_q & sda_q & ~sda_now;
   wire stop_seen  = scl_now & scl_q & ~sda_q & sda_now;
   wire rise       = scl_now & ~scl_q;
   wire fall       = ~scl_now & scl_q;
   wire byte_done  = bit_cnt == BITS_PER_BYTE;
   wire addr_match = shift[7:1] == DEVICE_ADDR;
   wire write_end  = fall & (state == LINK_WRITE) & byte_done;

   assign bus.rd_strobe = fall & (((state == LINK_ADDR_ACK) & reading)
                        | ((state == LINK_READ_ACK) & ~master_nack));
   assign bus.wr_strobe = write_end & ~pointer_phase;
   assign bus.ptr_load  = write_end & pointer_phase;
   assign bus.wr_data   = shift;
   assign bus.addr      = ptr;

   wire ptr_step = (bus.rd_strobe | bus.wr_strobe)
                 & (ptr != REG_FIFO_DATA) & (ptr != REG_LAST);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ptr <= READ_ZERO;
      end else if (bus.ptr_load) begin
         ptr <= shift;
      end else if (ptr_step) begin
         ptr <= ptr + 8'h01;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state         <= LINK_IDLE;
         bit_cnt       <= 4'h0;
         shift         <= 8'h00;
         tx            <= 8'h00;
         reading       <= 1'b0;
         pointer_phase <= 1'b0;
         master_nack   <= 1'b1;
         sda_oe        <= 1'b0;
      end else if (start_seen) begin
         state   <= LINK_ADDR;
         bit_cnt <= 4'h0;
         sda_oe  <= 1'b0;
      end else if (stop_seen) begin
         state  <= LINK_IDLE;
         sda_oe <= 1'b0;
      end else if (rise) begin
         shift       <= {shift[6:0], sda_now};
         bit_cnt     <= bit_cnt + 4'h1;
         master_nack <= sda_now;
      end else if (fall) begin
         case (state)
            LINK_IDLE: begin
               sda_oe <= 1'b0;
            end
            LINK_ADDR: begin
               if (byte_done && addr_match) begin
                  sda_oe  <= 1'b1;
                  reading <= shift[0];
                  state   <= LINK_ADDR_ACK;
               end else if (byte_done) begin
                  state <= LINK_IDLE;
               end
            end
            LINK_ADDR_ACK: begin
               bit_cnt <= 4'h0;
               if (reading) begin
                  tx     <= bus.rd_data;
                  sda_oe <= ~bus.rd_data[7];
                  state  <= LINK_READ;
               end else begin
                  sda_oe        <= 1'b0;
                  pointer_phase <= 1'b1;
                  state         <= LINK_WRITE;
               end
            end
            LINK_WRITE: begin
               if (byte_done) begin
                  sda_oe <= 1'b1;
                  state  <= LINK_WRITE_ACK;
               end
            end
            LINK_WRITE_ACK: begin
               sda_oe        <= 1'b0;
               bit_cnt       <= 4'h0;
               pointer_phase <= 1'b0;
               state         <= LINK_WRITE;
            end
            LINK_READ: begin
               if (byte_done) begin
                  sda_oe <= 1'b0;
                  state  <= LINK_READ_ACK;
               end else begin
                  sda_oe <= ~tx[3'h7 - bit_cnt[2:0]];
               end
            end
            LINK_READ_ACK: begin
               bit_cnt <= 4'h0;
               if (master_nack) begin
                  sda_oe <= 1'b0;
                  state  <= LINK_IDLE;
               end else begin
                  tx     <= bus.rd_data;
                  sda_oe <= ~bus.rd_data[7];
                  state  <= LINK_READ;
               end
            end
            default: begin
               state <= LINK_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** testbench/optical_sensor_ctrl_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module optical_sensor_ctrl_props (
   // Watched ports
   input wire logic       clock,
   input wire logic       rst_b,
   input wire logic       acquisition_enable,
   input wire logic [2:0] active_mode,
   input wire logic [1:0] adc_full_scale_select,
   input wire logic       power_save_request,
   input wire logic       almost_full_irq,
   input wire logic       power_ready_event,
   input wire logic       soft_reset_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire legal = active_mode inside {3'b010, 3'b011, 3'b111};
   sequence s_cleared;
      ##[0:2] (active_mode == 3'h0 && adc_full_scale_select == 2'h0 && !power_save_request);
   endsequence
   property p_irq_save; almost_full_irq |-> !power_save_request; endproperty
   property p_no_ready; soft_reset_busy |-> !power_ready_event; endproperty
   property p_ready_pulse; power_ready_event |=> (!power_ready_event) [*8]; endproperty
   property p_busy_idle; soft_reset_busy |-> !acquisition_enable; endproperty
   property p_mode_legal; acquisition_enable |-> legal; endproperty
   property p_acq_on;
      (legal && !power_save_request && !soft_reset_busy) |-> acquisition_enable;
   endproperty
   property p_srst_clear; $fell(soft_reset_busy) |-> s_cleared; endproperty
   property p_mode_keep;
      ($changed(active_mode) && !soft_reset_busy && !$past(soft_reset_busy))
         |-> $stable(adc_full_scale_select);
   endproperty
   a_irq_save: assert property (p_irq_save) else $error("irq in power save");
   a_no_ready: assert property (p_no_ready) else $error("ready during reset");
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready repeats");
   a_busy_idle: assert property (p_busy_idle) else $error("acquiring in reset");
   a_mode_legal: assert property (p_mode_legal) else $error("reserved mode runs");
   a_acq_on: assert property (p_acq_on) else $error("acquisition off");
   a_srst_clear: assert property (p_srst_clear) else $error("regs kept");
   a_mode_keep: assert property (p_mode_keep) else $error("range changed");
endmodule
bind optical_sensor_ctrl optical_sensor_ctrl_props i_optical_sensor_ctrl_props (
   .clock(clock), .rst_b(rst_b), .acquisition_enable(acquisition_enable),
   .active_mode(active_mode), .adc_full_scale_select(adc_full_scale_select),
   .power_save_request(power_save_request), .almost_full_irq(almost_full_irq),
   .power_ready_event(power_ready_event), .soft_reset_busy(soft_reset_busy));
`default_nettype wire

// *** testbench/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_model (
   // Serial pins
   input  wire logic sda,
   output var  logic scl,
   output var  logic host_oe
);
   initial begin
      scl = 1'b1;
      host_oe = 1'b0;
   end
   task automatic put_bit(input logic b, output logic r);
      host_oe = ~b;
      #100 scl = 1'b1;
      #100 r = sda;
      #100 scl = 1'b0;
      #100;
   endtask
   // Extra low time lets the device drop its acknowledge first
   task automatic start;
      host_oe = 1'b0;
      #200 scl = 1'b1;
      #100 host_oe = 1'b1;
      #100 scl = 1'b0;
      #100;
   endtask
   task automatic stop;
      host_oe = 1'b1;
      #100 scl = 1'b1;
      #100 host_oe = 1'b0;
      #200;
   endtask
   task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r,
                       output logic g);
      for (int i = 7; i >= 0; i--) put_bit(w[i], r[i]);
      put_bit(a, g);
   endtask
endmodule
`default_nettype wire

// *** testbench/optical_sensor_ctrl_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module optical_sensor_ctrl_tb;
   import sensor_pkg::*;
   logic                clock = 1'b0;
   logic                rst_b = 1'b0;
   logic                acq_valid = 1'b0;
   logic [SAMPLE_W-1:0] acq_red = '0;
   logic [SAMPLE_W-1:0] acq_ir = '0;
   logic                almost_full_ack = 1'b0;
   logic                g;
   logic [7:0]          rb [6];
   logic [7:0]          e [6] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'hff, 8'hfe};
   int                  n_fail = 0, n_checks = 0, cycles = 0, n_ready = 0;
   wire                 sda_oe, sda_out, scl, host_oe, acquisition_enable;
   wire                 power_save_request, almost_full_irq, power_ready_event;
   wire                 soft_reset_busy;
   wire [2:0]           active_mode;
   wire [1:0]           adc_full_scale_select;
   wire                 sda_in = ~(sda_oe | host_oe);
   host_model i_host_model (.sda(sda_in), .scl(scl), .host_oe(host_oe));
   optical_sensor_ctrl #(.SOFT_RESET_CYCLES(64)) i_optical_sensor_ctrl (.*);
   always #25 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (power_ready_event === 1'b1) n_ready++;
      if (cycles == 40000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic send(input logic [7:0] w);
      i_host_model.xfer(w, 1'b1, rb[0], g);
      chk({6'h0, g, sda_out}, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host_model.start();
      send(8'h54);
      send(a);
      send(d);
      i_host_model.stop();
   endtask
   task automatic rd(input logic [7:0] a, input int n);
      i_host_model.start();
      send(8'h54);
      send(a);
      i_host_model.start();
      send(8'h55);
      for (int i = 0; i < n; i++) i_host_model.xfer(8'hff, i == n - 1, rb[i], g);
      i_host_model.stop();
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      rd(a, 1);
      chk(rb[0], exp);
   endtask
   task automatic pair(input int k);
      @(posedge clock) #1 acq_red = 18'(2 * k);
      acq_ir = 18'h3ffff;
      acq_valid = 1'b1;
      @(posedge clock) #1 acq_red = 18'(2 * k + 2);
      acq_ir = 18'h3fffd;
      @(posedge clock) #1 acq_valid = 1'b0;
   endtask
   task automatic t_regs;
      rdchk(REG_FIFO_CONFIG, 8'h00);
      rdchk(REG_ACQ_CONFIG, 8'h00);
      wr(REG_ACQ_CONFIG, 8'h60);
      chk({6'h0, adc_full_scale_select}, 8'h03);
      wr(8'h20, 8'h5a);
      rdchk(8'h20, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_mode;
      for (int m = 0; m < 8; m++) begin
         wr(REG_MODE_CONFIG, m[7:0]);
         chk({7'h0, acquisition_enable}, {7'h0, m == 2 || m == 3 || m == 7});
         chk({3'h0, active_mode, adc_full_scale_select}, {3'h0, m[2:0], 2'h3});
      end
      $display("t_mode done");
   endtask
   task automatic t_fifo;
      wr(REG_MODE_CONFIG, 8'h03);
      wr(REG_FIFO_CONFIG, 8'h2f);
      for (int k = 0; k < 16; k++) pair(k);
      chk({7'h0, almost_full_irq}, 8'h00);
      pair(16);
      repeat (3) @(posedge clock);
      chk({7'h0, almost_full_irq}, 8'h01);
      wr(REG_MODE_CONFIG, 8'h83);
      chk({6'h0, power_save_request, almost_full_irq}, 8'h02);
      rdchk(REG_FIFO_CONFIG, 8'h2f);
      wr(REG_MODE_CONFIG, 8'h03);
      rdchk(REG_WRITE_INDEX, 8'h11);
      rd(REG_FIFO_DATA, 6);
      for (int i = 0; i < 6; i++) chk(rb[i], e[i]);
      rdchk(REG_READ_INDEX, 8'h01);
      wr(REG_READ_INDEX, 8'h00);
      repeat (3) @(posedge clock);
      chk({7'h0, almost_full_irq}, 8'h01);
      @(posedge clock) #1 almost_full_ack = 1'b1;
      @(posedge clock) #1 almost_full_ack = 1'b0;
      chk({7'h0, almost_full_irq}, 8'h00);
      for (int k = 17; k < 33; k++) pair(k);
      rdchk(REG_WRITE_INDEX, 8'h00);
      rdchk(REG_OVERFLOW_COUNT, 8'h01);
      wr(REG_FIFO_CONFIG, 8'h3f);
      pair(33);
      rdchk(REG_WRITE_INDEX, 8'h01);
      rdchk(REG_READ_INDEX, 8'h01);
      $display("t_fifo done");
   endtask
   task automatic t_srst;
      wr(REG_MODE_CONFIG, 8'h43);
      chk({7'h0, soft_reset_busy}, 8'h01);
      repeat (70) @(posedge clock);
      rdchk(REG_MODE_CONFIG, 8'h00);
      rdchk(REG_FIFO_CONFIG, 8'h00);
      rdchk(REG_WRITE_INDEX, 8'h00);
      chk(8'(n_ready), 8'h01);
      $display("t_srst done");
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #1 rst_b = 1'b1;
      repeat (6) @(posedge clock);
      t_regs();
      t_mode();
      t_fifo();
      t_srst();
      final_report();
   end
endmodule
`default_nettype wire
